// >>> bench/aec_core_checker.sv
// Port assertions for the exposure and gain controller
`timescale 1ns/1ps
module aec_core_checker
   import aec_pkg::*;
(
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire logic [31:0]      prdata,
   input wire logic             frame_end,
   input wire logic [EXP_W-1:0] exposure_time_out,
   input wire logic [EXP_W-1:0] frame_period_min,
   input wire logic             rate_reduced
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   logic [4:0] fe_age_r;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence access_s;
      psel && penable && !pready;
   endsequence
   // Loop result lands 13 edges after frame end, with margin
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) fe_age_r <= 5'h1f;
      else if (frame_end) fe_age_r <= 5'h00;
      else if (fe_age_r != 5'h1f) fe_age_r <= fe_age_r + 5'h01;
   a_one_wait: assert property (access_s |=> pready) else $error("pready not after one wait");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
   a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error reply");
   a_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0) else $error("write data leak");
   a_exp_range: assert property (exposure_time_out >= EXP_MODEL_MIN && exposure_time_out <= EXP_MODEL_MAX)
      else $error("exposure out of model range");
   a_period_track: assert property (1'b1 |=> frame_period_min == $past(exposure_time_out) + READOUT_OVH_US)
      else $error("period not exposure plus overhead");
   a_rate_flag: assert property (1'b1 |=> rate_reduced == ($past(frame_period_min) > BASE_PERIOD_US))
      else $error("rate flag wrong");
   a_exp_cause: assert property ($changed(exposure_time_out) |-> $past(pready && pwrite) || fe_age_r inside {[11:15]})
      else $error("exposure moved without cause");
endmodule : aec_core_checker

bind aec_core aec_core_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .prdata,
   .frame_end, .exposure_time_out, .frame_period_min, .rate_reduced);

// >>> bench/aec_core_tb.sv
// Self-checking bench for the exposure and gain controller
`timescale 1ns/1ps
module aec_core_tb;
   import aec_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, se, rate_reduced;
   logic              frame_start, line_start, frame_end, pix_valid, pix_in_image;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rd, seed;
   logic [PIX_W-1:0]  pix_data, v;
   logic [EXP_W-1:0]  exposure_time_out, frame_period_min, e0;
   logic [GAIN_W-1:0] gain_out;
   int                errors, checked, d;
   aec_core DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .frame_start, .line_start, .frame_end, .pix_valid, .pix_data, .pix_in_image,
      .exposure_time_out, .gain_out, .frame_period_min, .rate_reduced);
   always #12.5 pclk = ~pclk;
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Damped step with floor shift, minimum one unit, clamped to 100..5000
   function automatic logic [EXP_W-1:0] step(input int cur, input int err, input int dmp);
      int dl;
      dl = (err * dmp) >>> 7;
      if (dl == 0) dl = (err > 0) ? 1 : -1;
      dl = cur + dl;
      return (dl < 100) ? 20'd100 : (dl > 5000) ? 20'd5000 : EXP_W'(dl);
   endfunction : step
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      checked++;
      if (seen !== expv)
      begin
         errors++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, expv);
      end
   endtask : check
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] dt);
      int n;
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, dt};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      se = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
      if (n == 20)
      begin
         errors++;
         end_sim();
      end
   endtask : apb
   // Odd pixels inside the image carry v; even ones are outside and bright
   task automatic frame(input logic [PIX_W-1:0] pv);
      frame_start <= 1'b1;
      @(posedge pclk);
      {frame_start, line_start} <= 2'b01;
      for (int i = 0; i < 16; i++)
      begin
         @(posedge pclk);
         {line_start, pix_valid, pix_in_image} <= {2'b01, i[0]};
         pix_data <= i[0] ? pv : 12'hfff;
      end
      @(posedge pclk);
      {pix_valid, frame_end} <= 2'b01;
      @(posedge pclk);
      frame_end <= 1'b0;
      repeat (16) @(posedge pclk);
   endtask : frame
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {frame_start, line_start, frame_end, pix_valid, pix_in_image, pix_data} = '0;
      {errors, checked, seed} = {32'd0, 32'd0, 32'd72};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      check(exposure_time_out, EXP_RST);
      apb(ADDR_DAMP, 0, 0); check(rd, 32'h60);
      apb(ADDR_CTRL, 0, 0); check(rd, 0);
      apb(8'h38, 0, 0); check(se, 1); check(rd, 0);
      apb(8'h02, 1, 5); check(se, 1);
      for (int f = 1; f >= 0; f--)
      begin
         apb(ADDR_CTRL, 1, f << CTRL_FMT12_BIT);
         apb(ADDR_TARGET, 1, 0); apb(ADDR_TARGET, 0, 0); check(rd, f ? TARGET12_MIN : TARGET8_MIN);
         apb(ADDR_TARGET, 1, 32'hfff); apb(ADDR_TARGET, 0, 0); check(rd, f ? TARGET12_MAX : TARGET8_MAX);
      end
      apb(ADDR_EXPOSURE, 1, 0); check(exposure_time_out, EXP_MODEL_MIN);
      apb(ADDR_EXPOSURE, 1, 32'hfffff); check(exposure_time_out, EXP_MODEL_MAX);
      apb(ADDR_EXP_LO, 1, 100); apb(ADDR_EXP_HI, 1, 5000); apb(ADDR_EXPOSURE, 1, 1000);
      apb(ADDR_TARGET, 1, 128); apb(ADDR_CTRL, 1, 2);
      e0 = 1000;
      for (int k = 0; k < 8; k++)
      begin
         v = 20 + rnd() % 200;
         if (v > 125 && v < 131) v = 20;
         d = 1 + rnd() % 255;
         apb(ADDR_DAMP, 1, d);
         frame(v);
         e0 = step(e0, 128 - v, d);
         check(exposure_time_out, e0);
         check({frame_period_min, rate_reduced}, {e0 + 20'd10, e0 > 90});
         apb(ADDR_STATUS, 0, 0); check(rd[11:0], v);
      end
      $display("loop test done");
      apb(ADDR_CTRL, 1, 32'h22); frame(20); check(exposure_time_out, e0);
      apb(ADDR_CTRL, 1, 2); apb(ADDR_RGN_SPAN, 1, 1); frame(20); check(exposure_time_out, e0);
      apb(ADDR_STATUS, 0, 0); check(rd[16], 1);
      apb(ADDR_RGN_SPAN, 1, 32'h1fff);
      apb(ADDR_CTRL, 1, 1); frame(128); check(exposure_time_out, e0);
      apb(ADDR_CTRL, 0, 0); check(rd[1:0], 0);
      apb(ADDR_CTRL, 1, 32'h0a); frame(20); check({exposure_time_out, gain_out != 0}, {e0, 1'b1});
      apb(ADDR_CTRL, 1, 32'h1a); v = gain_out; frame(20); e0 = step(e0, 108, d);
      check({exposure_time_out, gain_out}, {e0, v});
      $display("mode tests done");
      end_sim();
   end
endmodule : aec_core_tb

// >>> src/aec_core.sv
// Auto exposure and gain control loop with APB register access
//
// What this block does
// - Trigger-width exposure mode inhibits the exposure loop
// - Exposure steps within bounds toward target mean
// - Loop modes: off, once, continuous
// - No region overlap: keep manual exposure
// - Clamp exposure to bounds within model limits
// - Target limited to 50-205 or 800-3280
// - Long exposure lengthens minimum line period
// - One target shared by both loops
// - Damping factor slows gray level changes
// - Damping factor resets to 0.75
// - Larger damping factor converges faster
// - Profile picks which quantity stays lowest
// - Mean over region and image intersection
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module aec_core
   import aec_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic [7:0]         paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               frame_start,
   input  wire logic               line_start,
   input  wire logic               frame_end,
   input  wire logic               pix_valid,
   input  wire logic [PIX_W-1:0]   pix_data,
   input  wire logic               pix_in_image,
   output logic [EXP_W-1:0]        exposure_time_out,
   output logic [GAIN_W-1:0]       gain_out,
   output logic [EXP_W-1:0]        frame_period_min,
   output logic                    rate_reduced
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      loop_mode_e         exposure_loop_mode;
      loop_mode_e         gain_loop_mode;
      logic               keep_gain_lowest;
      logic               trigger_width;
      logic               fmt12;
      logic [EXP_W-1:0]   exposure_time_setting;
      logic [EXP_W-1:0]   auto_exposure_lower_bound;
      logic [EXP_W-1:0]   auto_exposure_upper_bound;
      logic [PIX_W-1:0]   target_gray_level;
      logic [DAMP_W-1:0]  convergence_damping_factor;
      logic [POS_W-1:0]   measure_region_start_pixel;
      logic [POS_W-1:0]   measure_region_span;
      logic [LINES_W-1:0] measure_region_lines;
      logic [GAIN_W-1:0]  gain_setting;
      logic [GAIN_W-1:0]  gain_lower_bound;
      logic [GAIN_W-1:0]  gain_upper_bound;
      logic [PIX_W-1:0]   last_mean;
      logic               no_overlap;
      logic               converged;
      logic [EXP_W-1:0]   period_min;
      logic               rate_reduced;
      logic               pready;
      logic [31:0]        prdata;
      logic               pslverr;
   } core_s;

   localparam core_s CORE_RST = '{
      exposure_loop_mode:         LOOP_OFF,
      gain_loop_mode:             LOOP_OFF,
      keep_gain_lowest:           1'b0,    // default minimizes exposure
      trigger_width:              1'b0,
      fmt12:                      1'b0,
      exposure_time_setting:      EXP_RST,
      auto_exposure_lower_bound:  EXP_LO_RST,
      auto_exposure_upper_bound:  EXP_HI_RST,
      target_gray_level:          TARGET_RST,
      convergence_damping_factor: DAMP_RST,
      measure_region_start_pixel: RGN_START_RST,
      measure_region_span:        RGN_SPAN_RST,
      measure_region_lines:       RGN_LINES_RST,
      gain_setting:               GAIN_RST,
      gain_lower_bound:           GAIN_LO_RST,
      gain_upper_bound:           GAIN_HI_RST,
      last_mean:                  12'h000,
      no_overlap:                 1'b0,
      converged:                  1'b0,
      period_min:                 EXP_RST + READOUT_OVH_US,
      rate_reduced:               1'b1,
      pready:                     1'b0,
      prdata:                     32'h0,
      pslverr:                    1'b0
   };

   core_s r;
   core_s n;

   logic                mean_valid;
   logic [PIX_W-1:0]    mean;
   logic                no_overlap;
   logic [ERR_W-1:0]    err;
   logic [EXP_W-1:0]    exp_nxt;
   logic                exp_stuck;
   logic [EXP_W-1:0]    gain_nxt_w;
   logic                gain_stuck;

   // ------------------------------------------------------------------
   // Measurement and step datapaths
   // ------------------------------------------------------------------
   aec_region_stats u_stats (
      .pclk         (pclk),
      .presetn      (presetn),
      .frame_start  (frame_start),
      .line_start   (line_start),
      .frame_end    (frame_end),
      .pix_valid    (pix_valid),
      .pix_data     (pix_data),
      .pix_in_image (pix_in_image),
      .region_start (r.measure_region_start_pixel),
      .region_span  (r.measure_region_span),
      .region_lines (r.measure_region_lines),
      .mean_valid   (mean_valid),
      .mean         (mean),
      .no_overlap   (no_overlap)
   );

   // Shared target drives both loops
   assign err = {1'b0, r.target_gray_level} - {1'b0, mean};

   aec_damped_step u_exp_step (
      .cur   (r.exposure_time_setting),
      .lo    (r.auto_exposure_lower_bound),
      .hi    (r.auto_exposure_upper_bound),
      .err   (err),
      .damp  (r.convergence_damping_factor),
      .nxt   (exp_nxt),
      .stuck (exp_stuck)
   );

   aec_damped_step u_gain_step (
      .cur   ({8'h00, r.gain_setting}),
      .lo    ({8'h00, r.gain_lower_bound}),
      .hi    ({8'h00, r.gain_upper_bound}),
      .err   (err),
      .damp  (r.convergence_damping_factor),
      .nxt   (gain_nxt_w),
      .stuck (gain_stuck)
   );

   // ------------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------------
   function automatic logic [32:0] read_reg(input core_s s, input logic [7:0] a);
      logic [31:0] d;
      logic        ok;
      d  = 32'h0;
      ok = (a[1:0] == 2'b00);
      unique case (a)
         ADDR_CTRL:      d = {25'h0, s.fmt12, s.trigger_width, s.keep_gain_lowest,
                              s.gain_loop_mode, s.exposure_loop_mode};
         ADDR_EXPOSURE:  d = {12'h0, s.exposure_time_setting};
         ADDR_EXP_LO:    d = {12'h0, s.auto_exposure_lower_bound};
         ADDR_EXP_HI:    d = {12'h0, s.auto_exposure_upper_bound};
         ADDR_TARGET:    d = {20'h0, s.target_gray_level};
         ADDR_DAMP:      d = {24'h0, s.convergence_damping_factor};
         ADDR_RGN_START: d = {19'h0, s.measure_region_start_pixel};
         ADDR_RGN_SPAN:  d = {19'h0, s.measure_region_span};
         ADDR_RGN_LINES: d = {16'h0, s.measure_region_lines};
         ADDR_GAIN:      d = {20'h0, s.gain_setting};
         ADDR_GAIN_LO:   d = {20'h0, s.gain_lower_bound};
         ADDR_GAIN_HI:   d = {20'h0, s.gain_upper_bound};
         ADDR_STATUS:    d = {13'h0, s.rate_reduced, s.converged, s.no_overlap, 4'h0, s.last_mean};
         ADDR_PERIOD:    d = {12'h0, s.period_min};
         default:        ok = 1'b0;
      endcase
      read_reg = {ok, d};
   endfunction : read_reg

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb
   begin
      logic        exp_act;
      logic        gain_act;
      logic        conv;
      logic        pref_gain;
      logic        mv_exp;
      logic        mv_gain;
      logic [32:0] rd;
      logic [EXP_W-1:0] wexp;
      exp_act   = 1'b0;
      gain_act  = 1'b0;
      conv      = 1'b0;
      pref_gain = 1'b0;
      mv_exp    = 1'b0;
      mv_gain   = 1'b0;
      rd        = read_reg(r, paddr);
      wexp      = clamp_exp(pwdata[EXP_W-1:0], EXP_MODEL_MIN, EXP_MODEL_MAX);
      n = r;

      // Loop update once per measured frame
      exp_act  = (r.exposure_loop_mode != LOOP_OFF) && !r.trigger_width;
      gain_act = (r.gain_loop_mode != LOOP_OFF);
      if (mean_valid)
      begin
         n.last_mean  = mean;
         n.no_overlap = no_overlap;
         conv = $signed(err) <= $signed({1'b0, r.fmt12 ? TOL12 : TOL8})
             && $signed(err) >= -$signed({1'b0, r.fmt12 ? TOL12 : TOL8});
         if (!no_overlap)
         begin
            n.converged = conv;
            if (!conv)
            begin
               // Too dark with exposure kept lowest: raise gain first
               pref_gain = !err[ERR_W-1] ^ r.keep_gain_lowest;
               if (exp_act && gain_act)
               begin
                  mv_gain = pref_gain ? !gain_stuck : exp_stuck;
                  mv_exp  = !mv_gain;
               end
               else
               begin
                  mv_exp  = exp_act;
                  mv_gain = gain_act;
               end
               if (mv_exp)
                  n.exposure_time_setting = exp_nxt;
               if (mv_gain)
                  n.gain_setting = gain_nxt_w[GAIN_W-1:0];
            end
            // Single shot ends at target or at a bound
            if (exp_act && r.exposure_loop_mode == LOOP_ONCE && (conv || exp_stuck))
               n.exposure_loop_mode = LOOP_OFF;
            if (gain_act && r.gain_loop_mode == LOOP_ONCE && (conv || gain_stuck))
               n.gain_loop_mode = LOOP_OFF;
         end
      end

      // ----------------------------------------------------------------
      // APB slave, one wait state; write commits with pready high
      // ----------------------------------------------------------------
      if (psel && penable && !r.pready)
      begin
         n.pready  = 1'b1;
         n.prdata  = pwrite ? 32'h0 : rd[31:0];
         n.pslverr = !rd[32];
      end
      else if (psel && penable && r.pready)
      begin
         n.pready  = 1'b0;
         n.pslverr = 1'b0;
         // Software write wins over a same-cycle loop update
         if (pwrite && rd[32])
         begin
            unique case (paddr)
               ADDR_CTRL:
               begin
                  n.exposure_loop_mode = to_mode(pwdata[CTRL_EXP_MODE_LSB +: 2]);
                  n.gain_loop_mode     = to_mode(pwdata[CTRL_GAIN_MODE_LSB +: 2]);
                  n.keep_gain_lowest   = pwdata[CTRL_PROFILE_BIT];
                  n.trigger_width      = pwdata[CTRL_TRIGW_BIT];
                  n.fmt12              = pwdata[CTRL_FMT12_BIT];
                  n.converged          = 1'b0;
               end
               ADDR_EXPOSURE:  n.exposure_time_setting      = wexp;
               ADDR_EXP_LO:    n.auto_exposure_lower_bound  = wexp;
               ADDR_EXP_HI:    n.auto_exposure_upper_bound  = wexp;
               ADDR_TARGET:    n.target_gray_level = r.fmt12
                                  ? clamp_pix(pwdata[PIX_W-1:0], TARGET12_MIN, TARGET12_MAX)
                                  : clamp_pix(pwdata[PIX_W-1:0], TARGET8_MIN, TARGET8_MAX);
               ADDR_DAMP:      n.convergence_damping_factor = pwdata[DAMP_W-1:0];
               ADDR_RGN_START: n.measure_region_start_pixel = pwdata[POS_W-1:0];
               ADDR_RGN_SPAN:  n.measure_region_span        = pwdata[POS_W-1:0];
               ADDR_RGN_LINES: n.measure_region_lines       = pwdata[LINES_W-1:0];
               ADDR_GAIN:      n.gain_setting               = pwdata[GAIN_W-1:0];
               ADDR_GAIN_LO:   n.gain_lower_bound           = pwdata[GAIN_W-1:0];
               ADDR_GAIN_HI:   n.gain_upper_bound           = pwdata[GAIN_W-1:0];
               default:        n.pslverr                    = 1'b0;
            endcase
         end
      end
      else
      begin
         n.pready  = 1'b0;
         n.pslverr = 1'b0;
      end

      // A long exposure stretches the shortest line period
      n.period_min   = r.exposure_time_setting + READOUT_OVH_US;
      n.rate_reduced = r.period_min > BASE_PERIOD_US;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         r <= CORE_RST;
      else
         r <= n;
   end

   assign prdata            = r.prdata;
   assign pready            = r.pready;
   assign pslverr           = r.pslverr;
   assign exposure_time_out = r.exposure_time_setting;
   assign gain_out          = r.gain_setting;
   assign frame_period_min  = r.period_min;
   assign rate_reduced      = r.rate_reduced;

endmodule : aec_core

// >>> src/aec_damped_step.sv
// One damped, clamped adjustment step for exposure or gain
`timescale 1ns/1ps
module aec_damped_step
   import aec_pkg::*;
(
   input  wire logic [EXP_W-1:0]  cur,
   input  wire logic [EXP_W-1:0]  lo,
   input  wire logic [EXP_W-1:0]  hi,
   input  wire logic [ERR_W-1:0]  err,
   input  wire logic [DAMP_W-1:0] damp,
   output logic [EXP_W-1:0]       nxt,
   output logic                   stuck
);

   logic signed [21:0] prod;
   logic signed [21:0] delta;
   logic signed [22:0] sum;

   always_comb
   begin
      // Larger damping value means a bigger share of the error per frame
      prod  = $signed(err) * $signed({1'b0, damp});
      delta = prod >>> DAMP_FRAC;
      // Never stall on a small error
      if (err != '0 && delta == '0)
         delta = err[ERR_W-1] ? -22'sd1 : 22'sd1;
      sum = $signed({3'b000, cur}) + 23'(delta);
      if (sum < $signed({3'b000, lo}))
         nxt = lo;
      else if (sum > $signed({3'b000, hi}))
         nxt = hi;
      else
         nxt = sum[EXP_W-1:0];
      stuck = (err != '0) && (nxt == cur);
   end

endmodule : aec_damped_step

// >>> src/aec_pkg.sv
// Shared constants, register map and types of the auto exposure / gain controller
package aec_pkg;

   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int EXP_W     = 20;   // exposure in microseconds
   localparam int GAIN_W    = 12;
   localparam int PIX_W     = 12;
   localparam int POS_W     = 13;
   localparam int LINES_W   = 16;
   localparam int DAMP_W    = 8;
   localparam int DAMP_FRAC = 7;    // damping is unsigned Q1.7
   localparam int ERR_W     = 13;

   // ------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_EXPOSURE  = 8'h04;
   localparam logic [7:0] ADDR_EXP_LO    = 8'h08;
   localparam logic [7:0] ADDR_EXP_HI    = 8'h0c;
   localparam logic [7:0] ADDR_TARGET    = 8'h10;
   localparam logic [7:0] ADDR_DAMP      = 8'h14;
   localparam logic [7:0] ADDR_RGN_START = 8'h18;
   localparam logic [7:0] ADDR_RGN_SPAN  = 8'h1c;
   localparam logic [7:0] ADDR_RGN_LINES = 8'h20;
   localparam logic [7:0] ADDR_GAIN      = 8'h24;
   localparam logic [7:0] ADDR_GAIN_LO   = 8'h28;
   localparam logic [7:0] ADDR_GAIN_HI   = 8'h2c;
   localparam logic [7:0] ADDR_STATUS    = 8'h30;
   localparam logic [7:0] ADDR_PERIOD    = 8'h34;

   // ------------------------------------------------------------------
   // Control register field positions
   // ------------------------------------------------------------------
   localparam int CTRL_EXP_MODE_LSB  = 0;
   localparam int CTRL_GAIN_MODE_LSB = 2;
   localparam int CTRL_PROFILE_BIT   = 4;
   localparam int CTRL_TRIGW_BIT     = 5;
   localparam int CTRL_FMT12_BIT     = 6;

   // ------------------------------------------------------------------
   // Reset values and limits
   // ------------------------------------------------------------------
   localparam logic [EXP_W-1:0]   EXP_RST        = 20'h003e8;
   localparam logic [EXP_W-1:0]   EXP_LO_RST     = 20'h00064;
   localparam logic [EXP_W-1:0]   EXP_HI_RST     = 20'h01388;
   localparam logic [EXP_W-1:0]   EXP_MODEL_MIN  = 20'h00002;
   localparam logic [EXP_W-1:0]   EXP_MODEL_MAX  = 20'hf4240;
   localparam logic [GAIN_W-1:0]  GAIN_RST       = 12'h000;
   localparam logic [GAIN_W-1:0]  GAIN_LO_RST    = 12'h000;
   localparam logic [GAIN_W-1:0]  GAIN_HI_RST    = 12'hfff;
   localparam logic [PIX_W-1:0]   TARGET_RST     = 12'h080;
   localparam logic [PIX_W-1:0]   TARGET8_MIN    = 12'h032;
   localparam logic [PIX_W-1:0]   TARGET8_MAX    = 12'h0cd;
   localparam logic [PIX_W-1:0]   TARGET12_MIN   = 12'h320;
   localparam logic [PIX_W-1:0]   TARGET12_MAX   = 12'hcd0;
   localparam logic [PIX_W-1:0]   TOL8           = 12'h002;
   localparam logic [PIX_W-1:0]   TOL12          = 12'h020;
   localparam logic [DAMP_W-1:0]  DAMP_RST       = 8'h60;     // 0.75
   localparam logic [POS_W-1:0]   RGN_START_RST  = 13'h0000;
   localparam logic [POS_W-1:0]   RGN_SPAN_RST   = 13'h1fff;
   localparam logic [LINES_W-1:0] RGN_LINES_RST  = 16'h0080;
   localparam logic [EXP_W-1:0]   READOUT_OVH_US = 20'h0000a;
   localparam logic [EXP_W-1:0]   BASE_PERIOD_US = 20'h00064;

   typedef enum logic [1:0] {LOOP_OFF, LOOP_ONCE, LOOP_CONT} loop_mode_e;

   function automatic loop_mode_e to_mode(input logic [1:0] v);
      to_mode = (v == 2'h1) ? LOOP_ONCE : (v == 2'h2) ? LOOP_CONT : LOOP_OFF;
   endfunction : to_mode

   function automatic logic [EXP_W-1:0] clamp_exp(input logic [EXP_W-1:0] v,
                                                  input logic [EXP_W-1:0] lo,
                                                  input logic [EXP_W-1:0] hi);
      clamp_exp = (v < lo) ? lo : (v > hi) ? hi : v;
   endfunction : clamp_exp

   function automatic logic [PIX_W-1:0] clamp_pix(input logic [PIX_W-1:0] v,
                                                  input logic [PIX_W-1:0] lo,
                                                  input logic [PIX_W-1:0] hi);
      clamp_pix = (v < lo) ? lo : (v > hi) ? hi : v;
   endfunction : clamp_pix

endpackage : aec_pkg

// >>> src/aec_region_stats.sv
// Mean gray level of the measurement region, clipped to the image
`timescale 1ns/1ps
module aec_region_stats
   import aec_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               frame_start,
   input  wire logic               line_start,
   input  wire logic               frame_end,
   input  wire logic               pix_valid,
   input  wire logic [PIX_W-1:0]   pix_data,
   input  wire logic               pix_in_image,
   input  wire logic [POS_W-1:0]   region_start,
   input  wire logic [POS_W-1:0]   region_span,
   input  wire logic [LINES_W-1:0] region_lines,
   output logic                    mean_valid,
   output logic [PIX_W-1:0]        mean,
   output logic                    no_overlap
);

   typedef struct packed {
      logic [POS_W-1:0]   x;
      logic [LINES_W-1:0] line;
      logic [35:0]        sum;
      logic [23:0]        cnt;
      logic [35:0]        rem;
      logic [3:0]         bit_i;
      logic               busy;
      logic [PIX_W-1:0]   q;
      logic               done;
      logic               empty;
   } stats_s;

   stats_s r;
   stats_s n;

   always_comb
   begin
      logic [35:0]    trial;
      logic [POS_W:0] stop;
      trial = 36'h0;
      stop  = {1'b0, region_start} + {1'b0, region_span};
      n      = r;
      n.done = 1'b0;
      if (frame_start)
      begin
         n.line = '1;
         n.x    = '0;
         n.sum  = '0;
         n.cnt  = '0;
      end
      else if (line_start)
      begin
         n.line = r.line + 16'h0001;
         n.x    = '0;
      end
      else if (pix_valid)
      begin
         n.x = r.x + 13'h0001;
         // Only pixels inside both regions count
         if (pix_in_image && r.x >= region_start && {1'b0, r.x} < stop && r.line < region_lines)
         begin
            n.sum = r.sum + {24'h0, pix_data};
            n.cnt = r.cnt + 24'h000001;
         end
      end
      if (frame_end && !r.busy)
      begin
         n.busy  = 1'b1;
         n.rem   = r.sum;
         n.bit_i = 4'hb;
         n.q     = '0;
         n.empty = (r.cnt == 24'h0);
      end
      else if (r.busy)
      begin
         // Restoring divide, one quotient bit per cycle
         trial = {12'h0, r.cnt} << r.bit_i;
         if (r.rem >= trial)
         begin
            n.rem        = r.rem - trial;
            n.q[r.bit_i] = 1'b1;
         end
         if (r.bit_i == 4'h0)
         begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end
         else
            n.bit_i = r.bit_i - 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         r <= '0;
      else
         r <= n;
   end

   assign mean_valid = r.done;
   assign mean       = r.q;
   assign no_overlap = r.empty;

endmodule : aec_region_stats
